// >>> design/sio_defines.svh
// Purpose: constants of the system scan port
// Assumes: 250 MHz clock, even bit addresses
// Notes: offsets are bit addresses of the port
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH

`define SIO_ADDR_W 12
`define SIO_ADDR_HI 6'h10
`define SIO_BIT_CTRL 5'h00
`define SIO_BIT_P0 5'h10
`define SIO_P_SEL_LO 4'h0
`define SIO_P_SEG_LO 4'h4
`define SIO_P_RETRIG 4'hc
`define SIO_P_SHIFT 4'hd
`define SIO_P_BUZZ 4'he
`define SIO_P_TAPE 4'hf
`define SIO_P_RST 16'h1ff0
`define SIO_MASK_RST 16'h0000
`define SIO_IDLE_IN 9'h1ff
`define SIO_DIGITS 10
`define SIO_ROWS 9
`define SIO_COLS 5
`define SIO_SEGS 8
`define SIO_CLK_MHZ 250
`define SIO_FAILSAFE_US 1000
`define SIO_FAILSAFE_CYC (`SIO_FAILSAFE_US * `SIO_CLK_MHZ)
`define SIO_FS_W 20

`endif

// >>> design/sio_pkg.sv
// Purpose: types of the system scan port
// Assumes: nothing
// Notes: constants live in sio_defines.svh
package sio_pkg;
   typedef logic [3:0] sio_code_t;
   typedef logic [9:0] sio_digit_t;
   typedef enum logic {
      SIO_FS_LIT = 1'b0,
      SIO_FS_BLANK = 1'b1
   } sio_fs_state_t;
endpackage

// >>> design/sio_scan_if.sv
// Purpose: links the port core to decoder and fail-safe timer
// Assumes: one clock
// Notes: all signals are registered at their source
`timescale 1ns/1ps
interface sio_scan_if;
   import sio_pkg::*;
   sio_code_t code;
   sio_digit_t digit_n;
   logic retrig;
   logic enable_n;
   modport core (output code, output retrig, input digit_n, input enable_n);
   modport dec (input code, output digit_n);
   modport fs (input retrig, output enable_n);
endinterface

// >>> design/sio_digit_decode.sv
// Purpose: one-of-ten digit decoder, active low
// Assumes: code comes from a register
// Notes: codes 10 to 15 select no digit
`timescale 1ns/1ps
`include "sio_defines.svh"
module sio_digit_decode (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   sio_scan_if.dec scan
);
   import sio_pkg::*;
   sio_digit_t digit_n_q;
   sio_digit_t digit_n_d;

   always_comb begin
      digit_n_d = '1;
      for (int i = 0; i < `SIO_DIGITS; i++) begin
         if (scan.code == 4'(i)) begin
            digit_n_d[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         digit_n_q <= '1;
      end else begin
         digit_n_q <= digit_n_d;
      end
   end

   assign scan.digit_n = digit_n_q;
endmodule

// >>> design/sio_failsafe.sv
// Purpose: retriggerable fail-safe timer for the display
// Assumes: retrig is a one-cycle pulse
// Notes: display starts blanked until the first retrigger
`timescale 1ns/1ps
`include "sio_defines.svh"
module sio_failsafe #(
   parameter int unsigned CYCLES = `SIO_FAILSAFE_CYC
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   sio_scan_if.fs scan
);
   import sio_pkg::*;
   sio_fs_state_t state_q;
   sio_fs_state_t state_d;
   logic [`SIO_FS_W-1:0] cnt_q;
   logic [`SIO_FS_W-1:0] cnt_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (scan.retrig) begin
         state_d = SIO_FS_LIT;
         cnt_d = `SIO_FS_W'(CYCLES - 1);
      end else begin
         unique case (state_q)
            SIO_FS_LIT: begin
               if (cnt_q == '0) begin
                  state_d = SIO_FS_BLANK;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            SIO_FS_BLANK: begin
               cnt_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= SIO_FS_BLANK;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   assign scan.enable_n = state_q;
endmodule

// >>> design/sio_port.sv
// Purpose: bit-addressed system port for display, keys, tape and buzzer
// Assumes: host scans display and keys in software
// Notes: one bit per even address; read data one cycle after the strobe
`timescale 1ns/1ps
`include "sio_defines.svh"
module sio_port #(
   parameter int unsigned FAILSAFE_CYCLES = `SIO_FAILSAFE_CYC
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [`SIO_ADDR_W-1:0] addr_in,
   input wire logic wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic rdata_out,
   input wire logic [`SIO_COLS-1:0] key_column_n_in,
   input wire logic recorder_audio_input_in,
   output sio_pkg::sio_digit_t digit_sink_n_out,
   output logic [`SIO_ROWS-1:0] key_row_n_out,
   output logic [`SIO_SEGS-1:0] seg_source_out,
   output logic led_panel_enable_n_out,
   output logic shift_light_out,
   output logic buzzer_drive_out,
   output logic tape_write_out,
   output logic int_req_n_out,
   output sio_pkg::sio_code_t int_code_out
);
   import sio_pkg::*;

   sio_scan_if scan ();

   sio_digit_decode u_decode (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .scan(scan.dec)
   );

   sio_failsafe #(
      .CYCLES(FAILSAFE_CYCLES)
   ) u_failsafe (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .scan(scan.fs)
   );

   // pin synchronisers
   logic [5:0] pin_m_q;
   logic [5:0] pin_s_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_m_q <= '1;
         pin_s_q <= '1;
      end else begin
         pin_m_q <= {recorder_audio_input_in, key_column_n_in};
         pin_s_q <= pin_m_q;
      end
   end

   // register file
   logic ctrl_q;
   logic ctrl_d;
   logic [15:0] mask_q;
   logic [15:0] mask_d;
   logic [15:0] p_q;
   logic [15:0] p_d;
   logic rdata_q;
   logic rdata_d;
   logic [15:0] in_vec;
   logic [31:0] rd_vec;
   logic hit;
   logic [4:0] idx;

   assign hit = (addr_in[11:6] == `SIO_ADDR_HI) && !addr_in[0];
   assign idx = addr_in[5:1];
   // live levels, tape bit unchanged in polarity
   assign in_vec = {`SIO_IDLE_IN, pin_s_q, ctrl_q};
   assign rd_vec = {p_q, in_vec};

   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      p_d = p_q;
      rdata_d = 1'b0;
      if (wr_in && hit) begin
         if (idx == `SIO_BIT_CTRL) begin
            ctrl_d = wdata_in;
         end else if (idx < `SIO_BIT_P0) begin
            mask_d[idx[3:0]] = wdata_in;
         end else begin
            p_d[idx[3:0]] = wdata_in;
         end
      end
      if (rd_in && hit) begin
         rdata_d = rd_vec[idx];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= 1'b0;
         mask_q <= `SIO_MASK_RST;
         p_q <= `SIO_P_RST;
         rdata_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         p_q <= p_d;
         rdata_q <= rdata_d;
      end
   end

   // interrupt code and retrigger edge
   logic int_req_n_q;
   logic int_req_n_d;
   sio_code_t int_code_q;
   sio_code_t int_code_d;
   logic retrig_prev_q;
   logic retrig_q;
   logic retrig_d;

   always_comb begin
      int_req_n_d = 1'b1;
      int_code_d = '0;
      // mask gates the code, lowest line wins
      for (int i = 15; i >= 1; i--) begin
         if (!in_vec[i] && mask_q[i]) begin
            int_req_n_d = 1'b0;
            int_code_d = 4'(i);
         end
      end
      retrig_d = retrig_prev_q && !p_q[`SIO_P_RETRIG];
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         int_req_n_q <= 1'b1;
         int_code_q <= '0;
         retrig_prev_q <= 1'b1;
         retrig_q <= 1'b0;
      end else begin
         int_req_n_q <= int_req_n_d;
         int_code_q <= int_code_d;
         retrig_prev_q <= p_q[`SIO_P_RETRIG];
         retrig_q <= retrig_d;
      end
   end

   assign scan.retrig = retrig_q;
   assign scan.code = p_q[`SIO_P_SEL_LO +: 4];

   // output drivers
   logic [`SIO_SEGS-1:0] seg_q;
   logic [`SIO_SEGS-1:0] seg_d;
   logic [2:0] misc_q;
   logic [2:0] misc_d;

   always_comb begin
      // anode and panel enable both low
      seg_d = ~p_q[`SIO_P_SEG_LO +: `SIO_SEGS] & {`SIO_SEGS{~scan.enable_n}};
      // buzzer and tape write follow their bits directly
      misc_d = {p_q[`SIO_P_TAPE], p_q[`SIO_P_BUZZ], p_q[`SIO_P_SHIFT]};
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         seg_q <= '0;
         misc_q <= '0;
      end else begin
         seg_q <= seg_d;
         misc_q <= misc_d;
      end
   end

   assign rdata_out = rdata_q;
   // cathodes straight from the decoder flop
   assign digit_sink_n_out = scan.digit_n;
   // rows are digit lines 1 to 9
   assign key_row_n_out = scan.digit_n[`SIO_ROWS-1:0];
   assign seg_source_out = seg_q;
   assign led_panel_enable_n_out = scan.enable_n;
   assign shift_light_out = misc_q[0];
   assign buzzer_drive_out = misc_q[1];
   assign tape_write_out = misc_q[2];
   assign int_req_n_out = int_req_n_q;
   assign int_code_out = int_code_q;

   // checking helpers: cycles since the last retrigger, saturating
   logic [`SIO_FS_W-1:0] idle_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         idle_q <= '1;
      end else if (retrig_q) begin
         idle_q <= '0;
      end else if (idle_q != '1) begin
         idle_q <= idle_q + 1'b1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_seg_needs_enable: assert property (
      (|seg_source_out) |-> ($past(scan.enable_n) == 1'b0))
      else $error("segment sourced while panel disabled");

   a_digit1_code_zero: assert property (
      (scan.code == 4'h0) |=> (digit_sink_n_out[0] == 1'b0))
      else $error("code zero did not sink digit 1");

   a_digit_onehot: assert property (
      (scan.code < 4'ha) |=> $onehot(~digit_sink_n_out))
      else $error("digit lines not one of ten");

   a_digit_none_high: assert property (
      (scan.code >= 4'ha) |=> (&digit_sink_n_out))
      else $error("illegal code selected a digit");

   a_rows_follow: assert property (
      (scan.code < 4'h9) |=> (key_row_n_out == ~(9'h001 << $past(scan.code))))
      else $error("key row does not match digit");

   a_retrigger_lights: assert property (
      retrig_q |=> !scan.enable_n [*2])
      else $error("retrigger did not enable panel");

   a_blank_on_expire: assert property (
      (idle_q != '1) |-> (scan.enable_n == (idle_q >= `SIO_FS_W'(FAILSAFE_CYCLES))))
      else $error("fail-safe timing wrong");

   a_mask_blocks: assert property (
      (mask_q == 16'h0000) |=> int_req_n_out)
      else $error("masked input raised interrupt");

   a_col_readable: assert property (
      (rd_in && hit && idx == 5'h01) |=> (rdata_out == $past(pin_s_q[0])))
      else $error("key column 1 read wrong");

   a_tape_polarity: assert property (
      (rd_in && hit && idx == 5'h06) |=> (rdata_out == $past(pin_s_q[5])))
      else $error("tape read polarity wrong");

   a_buzzer_follow: assert property (
      $changed(p_q[`SIO_P_BUZZ]) |=> (buzzer_drive_out == $past(p_q[`SIO_P_BUZZ])))
      else $error("buzzer does not follow bit 14");

   a_unmapped_zero: assert property (
      (rd_in && !hit) |=> !rdata_out)
      else $error("unmapped read returned one");

   a_odd_ignored: assert property (
      (wr_in && addr_in[0]) |=> ($stable(p_q) && $stable(mask_q) && $stable(ctrl_q)))
      else $error("odd address write took effect");

   a_rdata_one_cycle: assert property (
      !(rd_in && hit) |=> !rdata_out)
      else $error("read data without a read");

   a_seg_lit: assert property (
      (!scan.enable_n && !p_q[`SIO_P_SEG_LO]) |=> seg_source_out[0])
      else $error("enabled segment A not sourced");

   a_unmasked_raises: assert property (
      (|(mask_q[15:1] & ~in_vec[15:1])) |=> !int_req_n_out)
      else $error("unmasked low line raised no request");

   a_lit_within_window: assert property (
      !scan.enable_n |-> (idle_q < `SIO_FS_W'(FAILSAFE_CYCLES)))
      else $error("panel lit outside fail-safe window");

   a_tape_follow: assert property (
      $changed(p_q[`SIO_P_TAPE]) |=> (tape_write_out == $past(p_q[`SIO_P_TAPE])))
      else $error("tape write does not follow bit 15");

   c_key_press: cover property (
      !digit_sink_n_out[0] && !pin_s_q[0]);
   c_expire: cover property (
      !scan.enable_n ##1 scan.enable_n);
   c_interrupt: cover property (
      !int_req_n_out && int_code_out == 4'h2);
   c_retrigger: cover property (
      retrig_q ##1 !scan.enable_n);
   c_tape_toggle: cover property (
      $changed(tape_write_out));
endmodule

// >>> sim/sio_key_matrix.sv
// Purpose: key matrix model on the far side of the scan port
// Assumes: rows are low active, a key joins one row to one column
// Notes: columns are pulled up, so open keys and unselected rows read one
`timescale 1ns/1ps
module sio_key_matrix (
   input wire logic [8:0] row_n_in,
   input wire logic [44:0] pressed_in,
   output logic [4:0] col_n_out
);
   always_comb begin
      col_n_out = 5'h1f;
      for (int r = 0; r < 9; r++) begin
         for (int c = 0; c < 5; c++) begin
            if (pressed_in[r * 5 + c] && (row_n_in[r] === 1'b0)) begin
               col_n_out[c] = 1'b0;
            end
         end
      end
   end
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the system scan port
// Assumes: fail-safe shortened to 20 cycles
// Notes: bit b of the port sits at address 0x400 + 2b
`timescale 1ns/1ps
module tb_top;
   import sio_pkg::*;
   logic clk_in, sys_rst_in, wdata_in, wr_in, rd_in, audio, rdata;
   logic en_n, buzz, tape, irq_n;
   logic shift, tape_loop, audio_pin;
   logic [11:0] addr_in;
   logic [44:0] pressed;
   logic [4:0] cols_n;
   logic [8:0] rows_n;
   logic [7:0] segs;
   logic [9:0] exp_d;
   sio_digit_t digit_n;
   sio_code_t icode;
   int errors = 0;
   int checked = 0;
   int cyc = 0;

   // recorder loopback plays the written tone back inverted
   assign audio_pin = tape_loop ? ~tape : audio;

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   sio_port #(.FAILSAFE_CYCLES(20)) dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
      .key_column_n_in(cols_n), .recorder_audio_input_in(audio_pin),
      .digit_sink_n_out(digit_n), .key_row_n_out(rows_n), .seg_source_out(segs),
      .led_panel_enable_n_out(en_n), .shift_light_out(shift), .buzzer_drive_out(buzz),
      .tape_write_out(tape), .int_req_n_out(irq_n), .int_code_out(icode)
   );

   sio_key_matrix model (.row_n_in(rows_n), .pressed_in(pressed), .col_n_out(cols_n));

   task automatic results;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wraw(input logic [11:0] a, input logic v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic wbit(input int b, input logic v);
      wraw(12'h400 + 12'(2 * b), v);
   endtask

   task automatic rget(input int b, output logic v);
      @(posedge clk_in);
      addr_in <= 12'h400 + 12'(2 * b);
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rbit(input int b, input logic exp, input string name);
      logic v;
      rget(b, v);
      check(name, 16'(v), 16'(exp));
   endtask

   task automatic set_code(input int c);
      for (int i = 0; i < 4; i++) begin
         wbit(16 + i, c[i]);
      end
   endtask

   // two full cycles, a one at twice the rate, time scaled
   task automatic fsk_bit(input logic v);
      logic lvl;
      logic seen;
      int t_prev;
      int half;
      t_prev = 0;
      half = 0;
      for (int i = 0; i < 4; i++) begin
         lvl = (i % 2 == 0);
         wbit(31, lvl);
         tick(v ? 4 : 12);
         rget(6, seen);
         check("tape_lvl", 16'(seen), 16'(!lvl));
         if (i > 0) begin
            half = cyc - t_prev;
         end
         t_prev = cyc;
      end
      // judged by rate alone, level may be inverted
      check("fsk_bit", 16'(half < 12), 16'(v));
   endtask

   task automatic trig;
      wbit(28, 1'b1);
      wbit(28, 1'b0);
   endtask

   // cut a hang short well past the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         results();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 12'h000;
      wdata_in = 1'b0;
      audio = 1'b0;
      pressed = '0;
      tape_loop = 1'b0;
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      #1 check("panel_n", 16'(en_n), 16'h1);
      check("digits", 16'(digit_n), 16'h3ff);
      wbit(20, 1'b0);
      trig();
      tick(3);
      check("seg_src", 16'(segs), 16'h01);
      check("digits", 16'(digit_n), 16'h3fe);
      for (int c = 0; c < 16; c++) begin
         set_code(c);
         tick(2);
         exp_d = (c < 10) ? ~(10'h1 << c) : 10'h3ff;
         check("digits", 16'(digit_n), 16'(exp_d));
         check("rows", 16'(rows_n), 16'(exp_d[8:0]));
      end
      // keys read while their digit is selected
      @(posedge clk_in);
      pressed <= 45'h800;
      set_code(2);
      tick(5);
      rbit(2, 1'b0, "col2");
      rbit(1, 1'b1, "col1");
      check("irq_n", 16'(irq_n), 16'h1);
      wbit(2, 1'b1);
      tick(4);
      check("irq_n", 16'(irq_n), 16'h0);
      check("icode", 16'(icode), 16'h2);
      wbit(2, 1'b0);
      set_code(3);
      tick(5);
      rbit(2, 1'b1, "col2_row4");
      @(posedge clk_in);
      audio <= 1'b1;
      tick(4);
      rbit(6, 1'b1, "tape_rd");
      @(posedge clk_in);
      audio <= 1'b0;
      tick(4);
      rbit(6, 1'b0, "tape_rd");
      wbit(30, 1'b1);
      wbit(31, 1'b1);
      wbit(29, 1'b1);
      tick(2);
      check("shift", 16'(shift), 16'h1);
      check("buzz", 16'(buzz), 16'h1);
      check("tape_wr", 16'(tape), 16'h1);
      rbit(30, 1'b1, "p14");
      wbit(30, 1'b0);
      wbit(32, 1'b1);
      tick(2);
      check("buzz", 16'(buzz), 16'h0);
      rbit(32, 1'b0, "unmapped_hi");
      rbit(-1, 1'b0, "unmapped_lo");
      wraw(12'h421, 1'b0);
      rbit(16, 1'b1, "p0_odd");
      wbit(31, 1'b0);
      @(posedge clk_in);
      tape_loop <= 1'b1;
      fsk_bit(1'b1);
      fsk_bit(1'b0);
      for (int k = 0; k < 4; k++) begin
         trig();
         tick(10);
         check("panel_n", 16'(en_n), 16'h0);
      end
      tick(30);
      check("panel_n", 16'(en_n), 16'h1);
      check("seg_src", 16'(segs), 16'h00);
      results();
   end
endmodule
